// ===== sram_host.v
// Host controller driving a 128K x 8 asynchronous static memory
`timescale 1ns/1ps
`include "sram_host_regs.vh"

// Functional notes
// - Read: selected, write strobe high, output gate low; byte driven out.
// - First of select or strobe going inactive ends the write.
// - Write data stable 25 ns before and 0 ns after write end.
// - Address valid 35 ns before write end and 0 ns before start.
// - Address held 0 ns after write end; write cycle at least 45 ns.
// - With gate low, strobe low time covers data setup plus float delay.
// - Host never drives data while device may be driving lines.
// - Address valid before or with select going active on reads.
module sram_host (
    input  wire                 core_clk_i,
    input  wire                 nrst_i,
    input  wire                 req_valid_i,
    output wire                 req_ready_o,
    input  wire                 req_write_i,
    input  wire [`ADDR_W-1:0]   req_addr_i,
    input  wire [`DATA_W-1:0]   req_wdata_i,
    output reg                  rsp_valid_o,
    output reg  [`DATA_W-1:0]   rsp_rdata_o,
    output reg  [`ADDR_W-1:0]   word_address_lines_o,
    output reg                  select_low_active_n_o,
    output reg                  select_high_active_o,
    output reg                  write_strobe_n_o,
    output reg                  output_gate_n_o,
    input  wire [`DATA_W-1:0]   byte_lines_i,
    output reg  [`DATA_W-1:0]   byte_lines_o,
    output reg                  byte_lines_oe_o
);

    localparam [2:0] ST_IDLE  = 3'd0;
    localparam [2:0] ST_READ  = 3'd1;
    localparam [2:0] ST_WRITE = 3'd2;
    localparam [2:0] ST_WHOLD = 3'd3;
    localparam [2:0] ST_GAP   = 3'd4;

    // Timing budget at a 5 ns clock
    // Read: address, selects and gate all move on one edge, so the
    // access time counts from that edge for address, select and gate.
    // The data pins are asynchronous to the core clock, so the byte
    // passes the pin synchroniser before it is captured; the gate is
    // held low through that latency so the device keeps driving.
    // Write: the strobe alone ends the write, with the gate held high,
    // so the low time covers the strobe width and the float time too.
    // A hold cycle follows the strobe edge before select and data drop.
    // Gap: after every transfer the bus rests for the change hold time
    // so that old read data never meets a new address on the pins.
    // Counts are worked out as integers and then cut to the counter
    // width on purpose; every count fits the counter by a wide margin.
    localparam integer READ_CYC_I  = `READ_ACCESS_CYC + `SYNC_CYC;
    localparam integer WLOW_CYC_I  = `WRITE_LOW_CYC;
    localparam integer WHOLD_CYC_I = `WRITE_HOLD_CYC;
    localparam integer GAP_CYC_I   = `GAP_CYC;

    // Counter loads for each phase
    localparam [`CNT_W-1:0] READ_CNT  = READ_CYC_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] WLOW_CNT  = WLOW_CYC_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] WHOLD_CNT = WHOLD_CYC_I[`CNT_W-1:0];
    localparam [`CNT_W-1:0] GAP_CNT   = GAP_CYC_I[`CNT_W-1:0];

    reg [2:0]        state_q;
    reg [`CNT_W-1:0] cnt_q;

    // Requests are taken only when idle
    assign req_ready_o = (state_q == ST_IDLE);

    // Agreed value of each data pin after synchronisation
    wire [`DATA_W-1:0] pin_agreed;

    // Three-stage synchroniser per data pin
    // Only the second stage reads the first, so a metastable first
    // stage never reaches the agreement logic. A change is accepted
    // once stages two and three hold the same level, which filters a
    // single sample taken while the pin was still settling.
    genvar gi;
    generate
        for (gi = 0; gi < `DATA_W; gi = gi + 1) begin : g_pin_sync
            reg s1_q;
            reg s2_q;
            reg s3_q;
            reg agreed_q;

            // Shift the pin through three stages
            always @(posedge core_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    s1_q     <= 1'b0;
                    s2_q     <= 1'b0;
                    s3_q     <= 1'b0;
                    agreed_q <= 1'b0;
                end else begin
                    s1_q <= byte_lines_i[gi];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        agreed_q <= s3_q; // Change counts once stages agree
                    end
                end
            end

            assign pin_agreed[gi] = agreed_q;
        end
    endgenerate

    // Cycle sequencer; all pins registered
    always @(posedge core_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state_q               <= ST_IDLE;
            cnt_q                 <= {`CNT_W{1'b0}};
            rsp_valid_o           <= 1'b0;
            rsp_rdata_o           <= {`DATA_W{1'b0}};
            word_address_lines_o  <= {`ADDR_W{1'b0}};
            select_low_active_n_o <= 1'b1;
            select_high_active_o  <= 1'b0;
            write_strobe_n_o      <= 1'b1;
            output_gate_n_o       <= 1'b1;
            byte_lines_o          <= {`DATA_W{1'b0}};
            byte_lines_oe_o       <= 1'b0;
        end else begin
            rsp_valid_o <= 1'b0;
            case (state_q)
                ST_IDLE: begin
                    if (req_valid_i) begin
                        // Address set with select, so it is valid at start
                        word_address_lines_o  <= req_addr_i;
                        select_low_active_n_o <= 1'b0;
                        select_high_active_o  <= 1'b1;
                        if (req_write_i) begin
                            // Gate stays high so device never drives lines
                            output_gate_n_o  <= 1'b1;
                            write_strobe_n_o <= 1'b0;
                            byte_lines_o     <= req_wdata_i;
                            byte_lines_oe_o  <= 1'b1;
                            cnt_q            <= WLOW_CNT;
                            state_q          <= ST_WRITE;
                        end else begin
                            write_strobe_n_o <= 1'b1;
                            output_gate_n_o  <= 1'b0;
                            byte_lines_oe_o  <= 1'b0;
                            cnt_q            <= READ_CNT;
                            state_q          <= ST_READ;
                        end
                    end
                end
                ST_READ: begin
                    if (cnt_q <= 1) begin
                        // Sample after the access time, then release
                        rsp_rdata_o           <= pin_agreed;
                        rsp_valid_o           <= 1'b1;
                        output_gate_n_o       <= 1'b1;
                        select_low_active_n_o <= 1'b1;
                        select_high_active_o  <= 1'b0;
                        cnt_q                 <= GAP_CNT;
                        state_q               <= ST_GAP;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_WRITE: begin
                    if (cnt_q <= 1) begin
                        // Strobe ends the write; select and data held after
                        write_strobe_n_o <= 1'b1;
                        cnt_q            <= WHOLD_CNT;
                        state_q          <= ST_WHOLD;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_WHOLD: begin
                    if (cnt_q <= 1) begin
                        // Deselect with gate still high keeps lines floating
                        select_low_active_n_o <= 1'b1;
                        select_high_active_o  <= 1'b0;
                        byte_lines_oe_o       <= 1'b0;
                        rsp_valid_o           <= 1'b1;
                        cnt_q                 <= GAP_CNT;
                        state_q               <= ST_GAP;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                ST_GAP: begin
                    if (cnt_q <= 1) begin
                        state_q <= ST_IDLE;
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

endmodule

// ===== sram_host_assertions.sv
// Pin timing checks for the memory host controller
`timescale 1ns/1ps
`include "sram_host_regs.vh"
module sram_host_assertions (
    input wire logic                core_clk_i,
    input wire logic                nrst_i,
    input wire logic                rsp_valid_o,
    input wire logic [`ADDR_W-1:0]  word_address_lines_o,
    input wire logic                select_low_active_n_o,
    input wire logic                select_high_active_o,
    input wire logic                write_strobe_n_o,
    input wire logic                output_gate_n_o,
    input wire logic [`DATA_W-1:0]  byte_lines_o,
    input wire logic                byte_lines_oe_o
);
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!nrst_i);
    // Strobe low eleven cycles; gate low nine access plus four sync cycles
    sequence s_wr_low; (!write_strobe_n_o)[*8] ##1 (!write_strobe_n_o)[*3]; endsequence
    sequence s_rd_low; (!output_gate_n_o)[*8] ##1 (!output_gate_n_o)[*5]; endsequence
    AST_WR_WIDTH: assert property ($fell(write_strobe_n_o) |-> s_wr_low ##1 write_strobe_n_o)
        else $error("strobe width wrong");
    AST_RD_LEN: assert property ($fell(output_gate_n_o) |-> s_rd_low ##1 (output_gate_n_o && rsp_valid_o))
        else $error("read length wrong");
    AST_WR_END: assert property ($rose(write_strobe_n_o) |=> select_low_active_n_o && !select_high_active_o && rsp_valid_o && !byte_lines_oe_o)
        else $error("write end wrong");
    AST_WR_HOLD: assert property ($rose(write_strobe_n_o) |-> byte_lines_oe_o && $stable(byte_lines_o) && $stable(word_address_lines_o))
        else $error("write hold lost");
    AST_DATA_HELD: assert property (!write_strobe_n_o && $past(!write_strobe_n_o) |-> $stable(byte_lines_o) && byte_lines_oe_o)
        else $error("write data moved");
    AST_ADDR_HELD: assert property (!select_low_active_n_o && $past(!select_low_active_n_o) |-> $stable(word_address_lines_o))
        else $error("address moved");
    AST_WR_SELECTED: assert property (!write_strobe_n_o |-> !select_low_active_n_o && select_high_active_o && output_gate_n_o)
        else $error("write unselected");
    AST_RD_NO_DRIVE: assert property (!output_gate_n_o |-> !byte_lines_oe_o && write_strobe_n_o && !select_low_active_n_o)
        else $error("drive during read");
    AST_SEL_PAIR: assert property (select_low_active_n_o != select_high_active_o)
        else $error("selects split");
endmodule

// ===== sram_host_regs.vh
// Timing constants for the asynchronous static memory host controller
`ifndef SRAM_HOST_REGS_VH
`define SRAM_HOST_REGS_VH

// Core clock period in picoseconds (200 MHz)
`define CLK_PERIOD_PS            5000

// Printed device times in nanoseconds
`define READ_CYCLE_MIN_NS        45
`define ADDRESS_ACCESS_DELAY_NS  45
`define SELECT_ACCESS_DELAY_NS   45
`define GATE_ACCESS_DELAY_NS     22
`define ADDRESS_CHANGE_HOLD_NS   10
`define DESELECT_POWERDOWN_NS    45
`define WRITE_CYCLE_MIN_NS       45
`define ADDRESS_TO_WRITE_END_NS  35
`define STROBE_LOW_WIDTH_NS      35
`define DATA_BEFORE_WRITE_END_NS 25
`define DATA_AFTER_WRITE_END_NS  0
`define ADDR_BEFORE_WR_START_NS  0
`define ADDR_HOLD_AFTER_WR_NS    0
`define STROBE_LOW_TO_FLOAT_NS   18

// Least times round up to whole cycles, never below one
`define NS_TO_CYC_UP(ns)  ((((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS) < 1 ? 1 : \
                           (((ns) * 1000 + `CLK_PERIOD_PS - 1) / `CLK_PERIOD_PS))

// Derived cycle counts
`define READ_ACCESS_CYC   `NS_TO_CYC_UP(`ADDRESS_ACCESS_DELAY_NS)
`define WRITE_LOW_CYC     `NS_TO_CYC_UP(`STROBE_LOW_WIDTH_NS + `STROBE_LOW_TO_FLOAT_NS)
`define WRITE_HOLD_CYC    `NS_TO_CYC_UP(`DATA_AFTER_WRITE_END_NS)
`define GAP_CYC           `NS_TO_CYC_UP(`ADDRESS_CHANGE_HOLD_NS)

// Extra read cycles: three pin stages plus the agreement register
`define SYNC_CYC          4

// Widths
`define ADDR_W            17
`define DATA_W            8
`define CNT_W             5

`endif

// ===== sram_host_tb_top.sv
// Self-checking bench for the memory host controller
`timescale 1ns/1ps
`include "sram_host_regs.vh"
module sram_host_tb_top;
    logic               core_clk_i, nrst_i, req_valid_i, req_write_i, req_ready_o, rsp_valid_o;
    logic               select_low_active_n_o, select_high_active_o, byte_lines_oe_o;
    logic               write_strobe_n_o, output_gate_n_o;
    logic [`ADDR_W-1:0] req_addr_i, word_address_lines_o;
    logic [`DATA_W-1:0] req_wdata_i, rsp_rdata_o, byte_lines_o, mem_dq;
    wire  [`DATA_W-1:0] byte_lines_i = byte_lines_oe_o ? byte_lines_o : mem_dq;
    int                 err_total = 0, total_checks = 0, n;
    // Rows: write flag, address, data written or expected
    logic [25:0]        rows [7] = '{26'h20000a5, 26'h3ffff5a, 26'h00000a5, 26'h1ffff5a,
                                     26'h200013c, 26'h000013c, 26'h00000a5};
    sram_host dut (.*);
    sram_model mem_u (.addr_i(word_address_lines_o), .sel_n_i(select_low_active_n_o),
        .sel_h_i(select_high_active_o), .we_n_i(write_strobe_n_o), .gate_n_i(output_gate_n_o),
        .d_i(byte_lines_o), .oe_i(byte_lines_oe_o), .dq_o(mem_dq));
    // Clock and watchdog, whole run is about 150 cycles
    initial begin
        core_clk_i = 1'b0;
        forever #2.5 core_clk_i = ~core_clk_i;
    end
    initial begin
        #5000;
        err_total++;
        finish_test;
    end
    task chk(input logic [31:0] s, input logic [31:0] e);
        total_checks++;
        if (s !== e) begin
            err_total++;
            $display("[ERR] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    // Request held through the take edge, then cycles counted to the answer
    task op(input logic [25:0] r);
        n = 0;
        while (req_ready_o !== 1'b1) @(negedge core_clk_i);
        @(posedge core_clk_i) {req_write_i, req_addr_i, req_wdata_i} <= r;
        req_valid_i <= 1'b1;
        @(posedge core_clk_i) req_valid_i <= 1'b0;
        do begin @(negedge core_clk_i); n++; end while (rsp_valid_o !== 1'b1 && n < 40);
    endtask
    task finish_test;
        $display("Checks %0d mismatches %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Table loop, then a reset in mid-read
    initial begin
        {nrst_i, req_valid_i, req_write_i, req_addr_i, req_wdata_i} = '0;
        repeat (6) @(posedge core_clk_i);
        nrst_i <= 1'b1;
        foreach (rows[i]) begin
            op(rows[i]);
            chk(n, rows[i][25] ? `WRITE_LOW_CYC + `WRITE_HOLD_CYC + 1 : `READ_ACCESS_CYC + `SYNC_CYC + 1);
            if (!rows[i][25]) chk(rsp_rdata_o, rows[i][7:0]);
            $display("Test %0d done", i);
        end
        while (req_ready_o !== 1'b1) @(negedge core_clk_i);
        @(posedge core_clk_i) req_valid_i <= 1'b1;
        @(posedge core_clk_i) req_valid_i <= 1'b0;
        repeat (4) @(posedge core_clk_i);
        nrst_i <= 1'b0;
        @(negedge core_clk_i);
        chk({select_low_active_n_o, select_high_active_o, write_strobe_n_o, output_gate_n_o,
             byte_lines_oe_o, rsp_valid_o, req_ready_o}, 7'h59);
        @(posedge core_clk_i) nrst_i <= 1'b1;
        op(rows[2]);
        chk(rsp_rdata_o, 8'ha5);
        $display("Test reset done");
        finish_test;
    end
endmodule
bind sram_host sram_host_assertions chk_u (.*);

// ===== sram_model.sv
// Behavioural 128K x 8 asynchronous memory
`timescale 1ns/1ps
module sram_model #(parameter ACCESS_NS = 44) (
    input  wire logic [16:0] addr_i,
    input  wire logic        sel_n_i,
    input  wire logic        sel_h_i,
    input  wire logic        we_n_i,
    input  wire logic        gate_n_i,
    input  wire logic [7:0]  d_i,
    input  wire logic        oe_i,
    output wire logic [7:0]  dq_o
);
    logic [7:0] mem [0:131071];
    wire sel = !sel_n_i && sel_h_i;
    wire rd  = sel && we_n_i && !gate_n_i;
    wire wr  = sel && !we_n_i;
    wire        rd_late;
    wire [16:0] a_late;
    // Access delay just inside the limit so sampling never races the edge
    assign #(ACCESS_NS) rd_late = rd;
    assign #(ACCESS_NS) a_late = addr_i;
    assign dq_o = (rd && rd_late && a_late == addr_i) ? mem[addr_i] : ~mem[addr_i];
    // First of select or strobe going inactive stores the byte
    always @(negedge wr) mem[addr_i] = oe_i ? d_i : 8'hxx;
endmodule
